// >>> design/wdmf_top.sv
// Purpose: watchdog timer with the shared multi-function timer
// Assumes: ref_clk is the system clock; core strobes are one-cycle pulses
// Notes: configuration options sit in registers on the plain port
//
// Behaviour
// - watchdog counts from watchdog oscillator, instruction clock, or RTC oscillator
// - disabled watchdog makes every watchdog operation a no-op
// - time-out equals source period times 2^12 up to 2^15
// - instruction-clock source stops counting during power down unless the system oscillator is 32k
// - overflow in normal run gives device reset and sets time-out flag
// - overflow in power down gives warm reset of counter and stack pointer only
// - count cleared by reset pin low, clear instruction or halt
// - single mode: each single clear instruction clears the count
// - paired mode: clear only after both first and second instructions
// - timer is an 8-stage divider followed by 7-bit prescaler
// - timer clock picked among watchdog oscillator, RTC oscillator, instruction clock
// - LCD clock tap from timer clock divided by 2^2 to 2^8
// - buzzer tap from timer clock divided by 2^2 to 2^9
// - power down halts RC or crystal system clock; 32k keeps timing running
// - RC mode drives system clock divided by 4 on the oscillator pin
// - quick-start bit 4 of RTC control; software clears it after 2s
// - watchdog oscillator runs in power down unless an option disables it
// - power-down flag cleared by power-up or clear, set by halt
//
// Decided for this implementation: the register addresses and the plain strobed port.
`include "wdmf_params.svh"
module wdmf_top
    import wdmf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic clr_single,
    input wire logic clr_first,
    input wire logic clr_second,
    input wire logic halt_exec,
    input wire logic wake_event,
    input wire logic external_reset_pin_n,
    input wire logic wdt_osc_in,
    input wire logic rtc_osc_in,
    output logic device_reset,
    output logic warm_reset,
    output logic timeout_status_flag,
    output logic powerdown_status_flag,
    output logic powered_down,
    output logic lcd_clk,
    output logic buzzer_out,
    output logic osc_output_pin_o,
    output logic osc_output_pin_oe,
    output logic rtc_quick_start
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_pipe;
    logic rst_sync_n;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] rtc_control_register;
        logic [7:0] taps;
        logic [7:0] rdata;
        logic [`WDMF_DIV_STAGES+`WDMF_PRE_BITS-1:0] cnt;
        wdmf_mode_type mode;
        logic to_flag;
        logic pd_flag;
        logic dev_rst;
        logic warm_rst;
        logic lcd;
        logic buz;
        logic [1:0] osc_div;
        logic osc_o;
        logic osc_oe;
        logic pin_s1;
        logic pin_s2;
    } wdmf_top_state_type;
    wdmf_top_state_type cur;
    wdmf_top_state_type next_cur;

    // ----------------------------------------
    // configuration fields
    // ----------------------------------------
    logic wdt_en;
    logic pair_mode;
    wdmf_src_type src_sel;
    logic [1:0] ratio;
    logic wdt_osc_en;
    logic [2:0] lcd_sel;
    logic [2:0] buz_sel;
    wdmf_sysosc_type sysosc;
    assign wdt_en = cur.cfg[0];
    assign pair_mode = cur.cfg[1];
    assign src_sel = wdmf_src_type'(cur.cfg[3:2]);
    assign ratio = cur.cfg[5:4];
    assign wdt_osc_en = cur.cfg[6];
    assign lcd_sel = (cur.taps[2:0] > `WDMF_LCD_SEL_MAX) ? `WDMF_LCD_SEL_MAX : cur.taps[2:0];
    assign buz_sel = cur.taps[5:3];
    assign sysosc = wdmf_sysosc_type'(cur.taps[7:6]);

    // ----------------------------------------
    // sub-modules
    // ----------------------------------------
    wdmf_if link ();
    logic sys_running;
    // rc and crystal stop in power down, the 32k system oscillator does not
    assign sys_running = (cur.mode == run_mode) || (sysosc == osc_32k);
    assign link.src_sel = cur.cfg[3:2];
    assign link.wdt_osc_en = wdt_osc_en;
    assign link.instr_run = sys_running;
    assign link.wdt_en = wdt_en;
    assign link.pair_mode = pair_mode;
    assign link.clr_single = clr_single & (cur.mode == run_mode);
    assign link.clr_first = clr_first & (cur.mode == run_mode);
    assign link.clr_second = clr_second & (cur.mode == run_mode);

    wdmf_srcsel u_src (
        .clk(ref_clk),
        .rst_n(rst_sync_n),
        .wdt_osc_in(wdt_osc_in),
        .rtc_osc_in(rtc_osc_in),
        .bus(link.src)
    );
    wdmf_clr u_clr (
        .clk(ref_clk),
        .rst_n(rst_sync_n),
        .bus(link.clr)
    );

    // ----------------------------------------
    // watchdog decisions
    // ----------------------------------------
    logic [`WDMF_DIV_STAGES+`WDMF_PRE_BITS-1:0] wdt_mask;
    logic ovf;
    logic halt_take;
    logic pin_low;
    logic clear_any;
    logic [3:0] lcd_idx;
    logic [3:0] buz_idx;
    always_comb begin
        case (ratio)
            2'h0: wdt_mask = `WDMF_MASK_R0;
            2'h1: wdt_mask = `WDMF_MASK_R1;
            2'h2: wdt_mask = `WDMF_MASK_R2;
            default: wdt_mask = `WDMF_MASK_R3;
        endcase
    end
    // overflow on the tick that completes 2^(12+ratio) source periods
    assign ovf = wdt_en && link.src_tick && ((cur.cnt & wdt_mask) == wdt_mask);
    assign halt_take = halt_exec && (cur.mode == run_mode);
    assign pin_low = !cur.pin_s2;
    assign clear_any = pin_low || link.clr_pulse || halt_take || ovf;
    assign lcd_idx = {1'b0, lcd_sel} + `WDMF_TAP_BASE;
    assign buz_idx = {1'b0, buz_sel} + `WDMF_TAP_BASE;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.pin_s1 = external_reset_pin_n;
        next_cur.pin_s2 = cur.pin_s1;
        next_cur.dev_rst = 1'b0;
        next_cur.warm_rst = 1'b0;
        // register port
        next_cur.rdata = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                `WDMF_ADDR_CFG: next_cur.cfg = reg_wdata;
                `WDMF_ADDR_RTC_CONTROL_REGISTER: next_cur.rtc_control_register = reg_wdata & `WDMF_RTC_CONTROL_REGISTER_MASK;
                `WDMF_ADDR_TAPS: next_cur.taps = reg_wdata;
                default: next_cur.cfg = cur.cfg;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `WDMF_ADDR_CFG: next_cur.rdata = cur.cfg;
                `WDMF_ADDR_RTC_CONTROL_REGISTER: next_cur.rdata = cur.rtc_control_register;
                `WDMF_ADDR_STAT: next_cur.rdata = {5'h00, cur.mode == pdown_mode, cur.pd_flag, cur.to_flag};
                `WDMF_ADDR_TAPS: next_cur.rdata = cur.taps;
                default: next_cur.rdata = 8'h00;
            endcase
        end
        // divider chain: 8-stage divider then 7-bit prescaler as one ripple count
        if (clear_any) begin
            next_cur.cnt = '0;
        end else if (link.src_tick) begin
            next_cur.cnt = cur.cnt + 1'b1;
        end
        // flags: clears first, so a set in the same cycle wins
        if (link.clr_pulse) begin
            next_cur.pd_flag = 1'b0;
        end
        if (halt_take) begin
            next_cur.pd_flag = 1'b1;
            next_cur.to_flag = 1'b0;
        end
        if (pin_low && cur.mode == pdown_mode) begin
            next_cur.to_flag = 1'b0;
        end
        case (cur.mode)
            run_mode: begin
                if (halt_take) begin
                    next_cur.mode = pdown_mode;
                end
                if (ovf) begin
                    next_cur.to_flag = 1'b1;
                    next_cur.dev_rst = 1'b1;
                end
            end
            pdown_mode: begin
                if (ovf) begin
                    next_cur.to_flag = 1'b1;
                    next_cur.warm_rst = 1'b1;
                    next_cur.mode = run_mode;
                end else if (pin_low || wake_event) begin
                    next_cur.mode = run_mode;
                end
            end
            default: next_cur.mode = run_mode;
        endcase
        // frequency taps
        next_cur.lcd = cur.cnt[lcd_idx];
        next_cur.buz = cur.cnt[buz_idx];
        // system clock over four on the oscillator pin, rc mode only
        next_cur.osc_div = sys_running ? cur.osc_div + 2'h1 : cur.osc_div;
        next_cur.osc_o = cur.osc_div[1];
        next_cur.osc_oe = (sysosc == osc_rc) && sys_running;
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cur <= '0;
            cur.cfg <= `WDMF_CFG_RESET;
            cur.rtc_control_register <= `WDMF_RTC_CONTROL_REGISTER_RESET;
            cur.taps <= `WDMF_TAPS_RESET;
            cur.mode <= run_mode;
            cur.pin_s1 <= 1'b1;
            cur.pin_s2 <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata = cur.rdata;
    assign device_reset = cur.dev_rst;
    assign warm_reset = cur.warm_rst;
    assign timeout_status_flag = cur.to_flag;
    assign powerdown_status_flag = cur.pd_flag;
    assign powered_down = cur.mode == pdown_mode;
    assign lcd_clk = cur.lcd;
    assign buzzer_out = cur.buz;
    assign osc_output_pin_o = cur.osc_o;
    assign osc_output_pin_oe = cur.osc_oe;
    // software boosts start-up, then drops the bit after about two seconds
    assign rtc_quick_start = cur.rtc_control_register[`WDMF_RTC_CONTROL_REGISTER_QSTART_BIT];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    chk_ovf_period: assert property (ovf |-> ((cur.cnt & wdt_mask) == wdt_mask) && link.src_tick)
        else $error("overflow before full period");
    chk_ovf_reset_run: assert property ((ovf && cur.mode == run_mode) |=>
        device_reset && timeout_status_flag && !warm_reset && cur.cnt == '0)
        else $error("normal overflow missed device reset");
    chk_ovf_warm_pd: assert property ((ovf && cur.mode == pdown_mode) |=>
        warm_reset && !device_reset && !powered_down && timeout_status_flag)
        else $error("power-down overflow missed warm reset");
    chk_instr_stops: assert property ((src_sel == src_instr && !sys_running) [*3] |->
        !link.src_tick)
        else $error("instruction source ticked in power down");
    chk_halt_clears: assert property (halt_take |=>
        powered_down && powerdown_status_flag && cur.cnt == '0)
        else $error("halt did not clear count or set flag");
    chk_pin_clears: assert property ((pin_low && !link.src_tick) |=> cur.cnt == '0)
        else $error("reset pin did not clear count");
    chk_single_clear: assert property ((wdt_en && !pair_mode && link.clr_single && !ovf) |=>
        cur.cnt == '0 && !powerdown_status_flag)
        else $error("single clear did not restart count");
    chk_disabled_noovf: assert property (!wdt_en |=> !device_reset && !warm_reset)
        else $error("disabled watchdog caused a reset");
    chk_lcd_tap: assert property (##1 lcd_clk == $past(cur.cnt[lcd_idx]))
        else $error("lcd tap wrong bit");
    chk_buz_tap: assert property (##1 buzzer_out == $past(cur.cnt[buz_idx]))
        else $error("buzzer tap wrong bit");
    chk_osc_pin_rc: assert property ((sysosc == osc_rc && sys_running) |=> osc_output_pin_oe)
        else $error("rc mode not driving oscillator pin");
    chk_osc_pin_pd: assert property ((sysosc != osc_32k && powered_down) [*2] |->
        !osc_output_pin_oe)
        else $error("halted oscillator still driving pin");

    cov_ovf_run: cover property (ovf && cur.mode == run_mode);
    cov_ovf_pd: cover property (ovf && cur.mode == pdown_mode);
    cov_halt_wake: cover property (halt_take ##[1:20] wake_event);
    cov_rtc_src: cover property (src_sel == src_rtc_osc && link.src_tick);
endmodule : wdmf_top

// >>> include/wdmf_params.svh
// Purpose: named constants for the watchdog and multi-function timer
// Assumes: 8-bit register port, 4-bit register index
// Notes: register offsets are word indices on the plain port
`ifndef WDMF_PARAMS_SVH
`define WDMF_PARAMS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define WDMF_ADDR_CFG 4'h0
`define WDMF_ADDR_RTC_CONTROL_REGISTER 4'h1
`define WDMF_ADDR_STAT 4'h2
`define WDMF_ADDR_TAPS 4'h3
`define WDMF_CFG_RESET 8'h41
`define WDMF_RTC_CONTROL_REGISTER_RESET 8'h00
`define WDMF_TAPS_RESET 8'h00
`define WDMF_RTC_CONTROL_REGISTER_QSTART_BIT 4
`define WDMF_RTC_CONTROL_REGISTER_MASK 8'h17
// ----------------------------------------
// timer geometry
// ----------------------------------------
`define WDMF_DIV_STAGES 8
`define WDMF_PRE_BITS 7
`define WDMF_MASK_R0 15'h0FFF
`define WDMF_MASK_R1 15'h1FFF
`define WDMF_MASK_R2 15'h3FFF
`define WDMF_MASK_R3 15'h7FFF
`define WDMF_TAP_BASE 4'h1
`define WDMF_LCD_SEL_MAX 3'h6
`define WDMF_INSTR_DIV_LAST 2'h3
`endif

// >>> include/wdmf_pkg.sv
// Purpose: shared types of the watchdog and multi-function timer
// Assumes: nothing beyond the params header
// Notes: only the enum types live here; each sub-module keeps its own state struct
package wdmf_pkg;
    typedef enum logic [1:0] {src_wdt_osc, src_instr, src_rtc_osc, src_none} wdmf_src_type;
    typedef enum logic [1:0] {osc_rc, osc_xtal, osc_32k, osc_spare} wdmf_sysosc_type;
    typedef enum logic {run_mode, pdown_mode} wdmf_mode_type;
endpackage : wdmf_pkg

// >>> include/wdmf_if.sv
// Purpose: carrier between timer core, source picker and clear logic
// Assumes: all signals on ref_clk
// Notes: clr_pulse is combinational from the clear module
interface wdmf_if;
    logic [1:0] src_sel;
    logic wdt_osc_en;
    logic instr_run;
    logic src_tick;
    logic wdt_en;
    logic pair_mode;
    logic clr_single;
    logic clr_first;
    logic clr_second;
    logic clr_pulse;
    modport src (input src_sel, input wdt_osc_en, input instr_run, output src_tick);
    modport clr (input wdt_en, input pair_mode, input clr_single, input clr_first, input clr_second,
        output clr_pulse);
    modport ctl (output src_sel, output wdt_osc_en, output instr_run, input src_tick,
        output wdt_en, output pair_mode, output clr_single, output clr_first, output clr_second,
        input clr_pulse);
endinterface : wdmf_if

// >>> design/wdmf_srcsel.sv
// Purpose: picks the timer source and turns it into one-cycle ticks
// Assumes: oscillator pins are slow against ref_clk
// Notes: tick is registered, one cycle after the detected edge
`include "wdmf_params.svh"
module wdmf_srcsel
    import wdmf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wdt_osc_in,
    input wire logic rtc_osc_in,
    wdmf_if.src bus
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] prev;
        logic [1:0] div;
        logic tick;
    } wdmf_src_state_type;
    wdmf_src_state_type cur;
    wdmf_src_state_type next_cur;
    logic [1:0] pins;
    logic [1:0] rise;
    assign pins = {rtc_osc_in, wdt_osc_in};
    // ----------------------------------------
    // per-oscillator synchroniser and edge find
    // ----------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_osc
        assign rise[g] = cur.s2[g] & ~cur.prev[g];
    end
    always_comb begin
        next_cur = cur;
        next_cur.s1 = pins;
        next_cur.s2 = cur.s1;
        next_cur.prev = cur.s2;
        // instruction clock stops while the system oscillator is halted
        next_cur.div = bus.instr_run ? cur.div + 2'h1 : cur.div;
        case (wdmf_src_type'(bus.src_sel))
            src_wdt_osc: next_cur.tick = rise[0] & bus.wdt_osc_en;
            src_instr: next_cur.tick = bus.instr_run && (cur.div == `WDMF_INSTR_DIV_LAST);
            src_rtc_osc: next_cur.tick = rise[1];
            default: next_cur.tick = 1'b0;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
    assign bus.src_tick = cur.tick;
    chk_osc_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (wdmf_src_type'(bus.src_sel) == src_wdt_osc && !bus.wdt_osc_en) |=> !bus.src_tick)
        else $error("tick from disabled watchdog oscillator");
endmodule : wdmf_srcsel

// >>> design/wdmf_clr.sv
// Purpose: single or paired watchdog clear instruction handling
// Assumes: instruction strobes are one-cycle pulses from the core
// Notes: a half pair is kept until the other half arrives
module wdmf_clr
    import wdmf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    wdmf_if.clr bus
);
    typedef struct packed {
        logic seen_first;
        logic seen_second;
    } wdmf_clr_state_type;
    wdmf_clr_state_type cur;
    wdmf_clr_state_type next_cur;
    logic pair_done;
    assign pair_done = (bus.clr_first | cur.seen_first) & (bus.clr_second | cur.seen_second);
    always_comb begin
        next_cur = cur;
        if (!bus.wdt_en || !bus.pair_mode || pair_done) begin
            next_cur = '0;
        end else begin
            next_cur.seen_first = cur.seen_first | bus.clr_first;
            next_cur.seen_second = cur.seen_second | bus.clr_second;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
    // disabled watchdog turns every clear into a no-op
    assign bus.clr_pulse = bus.wdt_en & (bus.pair_mode ? pair_done : bus.clr_single);
    chk_disabled_noclr: assert property (@(posedge clk) disable iff (!rst_n)
        !bus.wdt_en |-> !bus.clr_pulse)
        else $error("clear acted while watchdog disabled");
    chk_pair_needs_both: assert property (@(posedge clk) disable iff (!rst_n)
        (bus.pair_mode && bus.clr_second && !bus.clr_first && !cur.seen_first) |-> !bus.clr_pulse)
        else $error("paired clear fired on second half alone");
    cov_pair_clear: cover property (@(posedge clk) disable iff (!rst_n)
        bus.pair_mode && cur.seen_first && bus.clr_second);
endmodule : wdmf_clr

// >>> verification/wdmf_core_model.sv
// Purpose: core model issuing clear and halt strobes
// Assumes: one go pulse per instruction
// Notes: each strobe is registered and one cycle long
module wdmf_core_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] op,
    input wire logic go,
    output logic clr_single,
    output logic clr_first,
    output logic clr_second,
    output logic halt_exec
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // instruction strobes
    // ----
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {clr_single, clr_first, clr_second, halt_exec} <= 4'h0;
        end else begin
            clr_single <= go && op == 2'h0;
            clr_first <= go && op == 2'h1;
            clr_second <= go && op == 2'h2;
            halt_exec <= go && op == 2'h3;
        end
    end
endmodule : wdmf_core_model

// >>> verification/wdmf_top_tb_top.sv
// Purpose: self-checking bench for the watchdog timer
// Assumes: instruction clock source, ratio 2^12, about 16384 cycles to overflow
// Notes: tick phase unknown, so periods get a few cycles of slack
`include "wdmf_params.svh"
module wdmf_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic wake_event = 1'b0;
    logic external_reset_pin_n = 1'b1;
    logic wdt_osc_in = 1'b0;
    logic rtc_osc_in = 1'b0;
    logic [1:0] op = 2'h0;
    logic go = 1'b0;
    logic [7:0] reg_rdata;
    logic clr_single, clr_first, clr_second, halt_exec;
    logic device_reset, warm_reset, timeout_status_flag, powerdown_status_flag, powered_down;
    logic lcd_clk, buzzer_out, osc_output_pin_o, osc_output_pin_oe, rtc_quick_start;
    int errors = 0;
    int comparisons = 0;
    int c;
    int e[3];
    // ----
    // clocks and instances
    // ----
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        forever #1000 wdt_osc_in = ~wdt_osc_in;
    end
    initial begin
        forever #1525 rtc_osc_in = ~rtc_osc_in;
    end
    wdmf_core_model core (.clk(ref_clk), .rst_n(rst_n), .op(op), .go(go), .clr_single(clr_single),
        .clr_first(clr_first), .clr_second(clr_second), .halt_exec(halt_exec));
    wdmf_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clr_single(clr_single),
        .clr_first(clr_first), .clr_second(clr_second), .halt_exec(halt_exec),
        .wake_event(wake_event), .external_reset_pin_n(external_reset_pin_n),
        .wdt_osc_in(wdt_osc_in), .rtc_osc_in(rtc_osc_in), .device_reset(device_reset),
        .warm_reset(warm_reset), .timeout_status_flag(timeout_status_flag),
        .powerdown_status_flag(powerdown_status_flag), .powered_down(powered_down),
        .lcd_clk(lcd_clk), .buzzer_out(buzzer_out), .osc_output_pin_o(osc_output_pin_o),
        .osc_output_pin_oe(osc_output_pin_oe), .rtc_quick_start(rtc_quick_start));
    // ----
    // shared tasks
    // ----
    task automatic end_sim;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string msg);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, msg);
    endtask : rd
    task automatic ins(input logic [1:0] o);
        @(posedge ref_clk);
        op <= o;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (2) @(posedge ref_clk);
        // step off the edge so callers see settled outputs
        #1;
    endtask : ins
    // bounded wait; a missing pulse that was due ends the run
    task automatic wait_rst(input int n, input bit must);
        c = 0;
        while (c < n && device_reset !== 1'b1 && warm_reset !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            c++;
        end
        if (must && c >= n) begin
            errors++;
            $display("wrong value at %0t: no reset pulse", $time);
            end_sim();
        end
    endtask : wait_rst
    task automatic edges(input int n);
        logic [2:0] p;
        e = '{0, 0, 0};
        p = {osc_output_pin_o, lcd_clk, buzzer_out};
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            e[0] += int'(osc_output_pin_o !== p[2]);
            e[1] += int'(lcd_clk !== p[1]);
            e[2] += int'(buzzer_out !== p[0]);
            p = {osc_output_pin_o, lcd_clk, buzzer_out};
        end
    endtask : edges
    // ----
    // scenarios
    // ----
    task automatic t_regs;
        rd(4'h0, 8'h41, "cfg reset");
        rd(4'h3, 8'h00, "taps reset");
        rd(4'hF, 8'h00, "unmapped read");
        wr(4'h1, 8'hFF);
        wr(4'h2, 8'hFF);
        rd(4'h1, 8'h17, "rtc control");
        chk({7'h00, rtc_quick_start}, 8'h01, "quick start");
        rd(4'h2, 8'h00, "status");
        wr(4'h1, 8'h00);
    endtask : t_regs
    task automatic t_taps;
        wr(4'h0, 8'h45);
        wr(4'h3, 8'h08);
        ins(2'h0);
        edges(800);
        chk({7'h00, osc_output_pin_oe}, 8'h01, "osc pin enable");
        chk(8'(e[0] inside {[399:401]}), 8'h01, "osc pin rate");
        chk(8'(e[1] inside {[99:101]}), 8'h01, "lcd rate");
        chk(8'(e[2] inside {[49:51]}), 8'h01, "buzzer rate");
    endtask : t_taps
    task automatic t_single;
        ins(2'h0);
        wait_rst(2000, 1'b0);
        ins(2'h0);
        // 17000 cycles since the first clear: only a restart avoids overflow
        wait_rst(15000, 1'b0);
        chk(8'(c == 15000), 8'h01, "single clear");
    endtask : t_single
    task automatic t_pair;
        wr(4'h0, 8'h47);
        ins(2'h1);
        ins(2'h2);
        wait_rst(2000, 1'b0);
        ins(2'h1);
        ins(2'h0);
        wait_rst(16000, 1'b1);
        chk({6'h00, device_reset, warm_reset}, 8'h02, "run overflow");
        rd(4'h2, 8'h01, "timeout flag");
        wait_rst(2000, 1'b0);
        ins(2'h2);
        ins(2'h1);
        wait_rst(15000, 1'b0);
        chk(8'(c == 15000), 8'h01, "paired clear");
    endtask : t_pair
    task automatic t_disabled;
        wr(4'h0, 8'h44);
        ins(2'h0);
        wait_rst(16500, 1'b0);
        chk(8'(c == 16500), 8'h01, "disabled");
    endtask : t_disabled
    task automatic t_pd_stop;
        wr(4'h0, 8'h45);
        wr(4'h3, 8'h00);
        ins(2'h3);
        chk({6'h00, powered_down, osc_output_pin_oe}, 8'h02, "rc halt");
        rd(4'h2, 8'h06, "halt flags");
        wait_rst(16500, 1'b0);
        chk(8'(c == 16500), 8'h01, "instr stop");
        wake_event <= 1'b1;
        @(posedge ref_clk);
        wake_event <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({7'h00, powered_down}, 8'h00, "wake");
    endtask : t_pd_stop
    task automatic t_warm;
        wr(4'h3, 8'h80);
        ins(2'h3);
        wait_rst(16500, 1'b1);
        chk(8'(c inside {[16370:16392]}), 8'h01, "period");
        chk({6'h00, device_reset, warm_reset}, 8'h01, "pd overflow");
        rd(4'h2, 8'h03, "warm flags");
    endtask : t_warm
    task automatic t_pin;
        wr(4'h3, 8'h00);
        ins(2'h3);
        external_reset_pin_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        external_reset_pin_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(4'h2, 8'h02, "pin in halt");
    endtask : t_pin
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_regs();
        t_taps();
        t_single();
        t_pair();
        t_disabled();
        t_pd_stop();
        t_warm();
        t_pin();
        end_sim();
    end
    initial begin
        #(50 * 104000);
        errors++;
        $display("wrong value at %0t: run too long", $time);
        end_sim();
    end
endmodule : wdmf_top_tb_top
